// ===== src/dfp_pkg.sv
// Purpose: shared constants and types for the diskette function protocol block
// Assumes: 200 MHz CLOCK, one clock domain
// Notes: register layouts, function codes, states and carriers
package dfp_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SHIFT_TIME_NS = 40;
  localparam int SHIFT_CYC_I = (SHIFT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] SHIFT_CYC = 4'(SHIFT_CYC_I);
  // ****************************************
  // command_status_reg fields
  // ****************************************
  localparam int CS_GO = 0;
  localparam int CS_FUNC_LO = 1;
  localparam int CS_UNIT = 4;
  localparam int CS_DONE = 5;
  localparam int CS_IE = 6;
  localparam int CS_TR = 7;
  localparam int CS_DENS = 8;
  localparam int CS_INIT = 14;
  localparam int CS_ERR = 15;
  // ****************************************
  // error_and_drive_status fields
  // ****************************************
  localparam int ES_CRC = 0;
  localparam int ES_INITDONE = 2;
  localparam int ES_DENSERR = 3;
  localparam int ES_COMPAT = 4;
  localparam int ES_DOUBLE = 5;
  localparam int ES_DELETED = 6;
  localparam int ES_RDY = 7;
  localparam int ES_UNIT = 8;
  // ****************************************
  // sizes and media constants
  // ****************************************
  localparam logic [7:0] BUF_BYTES = 8'h80;
  localparam logic [7:0] REC_BYTES = 8'h82;
  localparam logic [7:0] CRC_HI_IDX = 8'h80;
  localparam logic [7:0] NUM_TRACKS = 8'h4d;
  localparam logic [7:0] NUM_SECTORS = 8'h1a;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic SEL_CS = 1'b0;
  localparam logic SEL_DB = 1'b1;

  typedef enum logic [2:0] {
    FN_FILL = 3'h0, FN_EMPTY = 3'h1, FN_WRITE = 3'h2, FN_READ = 3'h3,
    FN_UNUSED = 3'h4, FN_STATUS = 3'h5, FN_WRDEL = 3'h6, FN_ERRCODE = 3'h7
  } dfp_func_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_GET_SEC = 4'h1, ST_GET_TRK = 4'h3, ST_CHECK = 4'h2,
    ST_MEDIA = 4'h6, ST_WR_XFER = 4'h7, ST_RD_XFER = 4'h5, ST_FINISH = 4'h4,
    ST_FILL = 4'hc, ST_EMPTY = 4'hd, ST_STAT = 4'hf, ST_INIT = 4'he, ST_PWRDN = 4'ha
  } dfp_state_t;

  // host pins and drive pins, synchronised as one group
  typedef struct packed {
    logic pwr_ok;
    logic bus_init;
    logic compat;
    logic [1:0] rdy;
    logic [1:0] dbl;
    logic wr;
    logic rd;
    logic sel;
    logic [15:0] wdata;
  } dfp_pins_t;

  typedef struct packed {
    dfp_state_t state;
    dfp_pins_t sy1;
    dfp_pins_t sy2;
    logic wr_q;
    logic rd_q;
    logic cs_ie;
    logic cs_err;
    logic cs_done;
    logic cs_tr;
    logic unit;
    logic fdens;
    dfp_func_t func;
    logic [15:0] db;
    logic [7:0] track;
    logic [7:0] sector;
    logic crc_err;
    logic init_done;
    logic dens_err;
    logic drv_dens;
    logic deleted;
    logic drive_ready_flag;
    logic [7:0] count;
    logic [3:0] shift_cnt;
    logic [15:0] init_cnt;
    logic [15:0] crc;
    logic [15:0] rdata;
    logic irq;
    logic med_go;
    logic wr_valid;
    logic [7:0] wr_data;
  } dfp_st_t;
endpackage

// ===== src/dfp_top.sv
// Purpose: diskette function protocol controller, host registers to media engine
// Assumes: host strobes and drive status arrive asynchronously; media engine on CLOCK
// Notes: sector buffer held here; read stream passes a 16-byte FIFO
//
// Overview of operation
// - track register keeps low byte only
// - sector register keeps low byte only
// - completion copies status word into data port
// - initialize completion sets initialize-complete bit
// - density mismatch stops with error and done
// - density bit 5; compat mode sets bit 4 only on double density
// - drive ready sampled at status or initialize
// - status bit 8 shows selected drive
// - function code bits 1-3, only when done
// - fill clears status, done; byte handshake
// - fill completes after exactly 128 bytes
// - empty presents 128 bytes, buffer kept
// - write takes sector then track address
// - missing track aborts with error and done
// - missing sector aborts, request stays low
// - write records 128 bytes plus CRC
// - invalid buffer still written with valid CRC
// - read clears status, takes sector, track
// - deleted data mark sets status bit 6
// - nonzero CRC residue sets errors
// - read status samples selected drive, done
// - data port takes writes when idle, otherwise only on request
// - new command or initialize clears error
// - done with enable raises interrupt; init clears
`timescale 1ns/1ps

// ****************************************
// fifo
// ****************************************
module dfp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] cnt;
    logic rdy;
  } dfp_fifo_st_t;
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
  logic [WIDTH-1:0] mem [DEPTH];
  dfp_fifo_st_t s;
  dfp_fifo_st_t n;
  logic push;
  logic pop;

  assign in_ready = s.rdy;
  assign out_valid = (s.cnt != '0);
  assign out_data = mem[s.rptr];

  always_comb begin
    n = s;
    push = in_valid & s.rdy;
    pop = out_ready & (s.cnt != '0);
    if (push) begin
      n.wptr = (s.wptr == LAST_PTR) ? '0 : s.wptr + 1'b1;
    end
    if (pop) begin
      n.rptr = (s.rptr == LAST_PTR) ? '0 : s.rptr + 1'b1;
    end
    n.cnt = s.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    // ready is a flop so the media side sees a clean level
    n.rdy = (n.cnt != FULL_CNT);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{rdy: 1'b1, default: '0};
    end else begin
      s <= n;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[s.wptr] <= in_data;
    end
  end
endmodule // dfp_fifo

// ****************************************
// controller
// ****************************************
module dfp_top #(
  parameter logic [15:0] INIT_CYCLES = 16'h03e8,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic HOST_SEL,
  input wire logic HOST_WR,
  input wire logic HOST_RD,
  input wire logic [15:0] HOST_WDATA,
  output logic [15:0] HOST_RDATA,
  output logic HOST_IRQ,
  input wire logic PWR_OK,
  input wire logic BUS_INIT,
  input wire logic COMPAT_MODE,
  input wire logic [1:0] DRV_READY,
  input wire logic [1:0] DRV_DOUBLE,
  output logic MED_GO,
  output logic MED_WRITE,
  output logic MED_DELMARK,
  output logic MED_UNIT,
  output logic MED_DOUBLE,
  output logic [7:0] MED_TRACK,
  output logic [7:0] MED_SECTOR,
  input wire logic MED_FOUND,
  input wire logic MED_TRK_ERR,
  input wire logic MED_SEC_ERR,
  input wire logic MED_DELETED,
  output logic [7:0] MED_WR_DATA,
  output logic MED_WR_VALID,
  input wire logic MED_WR_READY,
  input wire logic [7:0] MED_RD_DATA,
  input wire logic MED_RD_VALID,
  output logic MED_RD_READY
);
  localparam logic [15:0] INIT_LAST = INIT_CYCLES - 16'h0001;
  logic [7:0] sbuf [128];
  dfp_pkg::dfp_st_t s;
  dfp_pkg::dfp_st_t n;
  dfp_pkg::dfp_pins_t pins;
  logic wr_ev;
  logic rd_ev;
  logic cs_wr;
  logic db_wr;
  logic buf_we;
  logic [7:0] buf_wd;
  logic [7:0] buf_rd;
  logic f_valid;
  logic [7:0] f_data;
  logic f_ready;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    logic fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[15] ^ d[i];
      r = {r[14:0], 1'b0};
      if (fb) begin
        r = r ^ dfp_pkg::CRC_POLY;
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] stat_word(input dfp_pkg::dfp_st_t t);
    logic [15:0] w;
    w = '0;
    w[dfp_pkg::ES_CRC] = t.crc_err;
    w[dfp_pkg::ES_INITDONE] = t.init_done;
    w[dfp_pkg::ES_DENSERR] = t.dens_err;
    w[dfp_pkg::ES_DOUBLE] = t.drv_dens;
    w[dfp_pkg::ES_COMPAT] = t.sy2.compat & t.drv_dens;
    w[dfp_pkg::ES_DELETED] = t.deleted;
    w[dfp_pkg::ES_RDY] = t.drive_ready_flag;
    w[dfp_pkg::ES_UNIT] = t.unit;
    return w;
  endfunction

  function automatic logic [15:0] cs_word(input dfp_pkg::dfp_st_t t);
    logic [15:0] w;
    w = '0;
    w[dfp_pkg::CS_DONE] = t.cs_done;
    w[dfp_pkg::CS_IE] = t.cs_ie;
    w[dfp_pkg::CS_TR] = t.cs_tr;
    w[dfp_pkg::CS_ERR] = t.cs_err;
    return w;
  endfunction

  // ****************************************
  // datapath glue
  // ****************************************
  assign pins = '{pwr_ok: PWR_OK, bus_init: BUS_INIT, compat: COMPAT_MODE, rdy: DRV_READY,
                  dbl: DRV_DOUBLE, wr: HOST_WR, rd: HOST_RD, sel: HOST_SEL, wdata: HOST_WDATA};
  assign buf_rd = sbuf[s.count[6:0]];
  // drain stalls outside the read transfer, so the FIFO backs up onto the engine
  assign f_ready = (s.state == dfp_pkg::ST_RD_XFER) && (s.count < dfp_pkg::REC_BYTES);

  dfp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
    .clk(CLOCK),
    .rst_n(RSTN),
    .in_valid(MED_RD_VALID),
    .in_data(MED_RD_DATA),
    .in_ready(MED_RD_READY),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(f_ready)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n = s;
    buf_we = 1'b0;
    buf_wd = 8'h00;
    n.sy1 = pins;
    n.sy2 = s.sy1;
    n.wr_q = s.sy2.wr;
    n.rd_q = s.sy2.rd;
    wr_ev = s.sy2.wr & ~s.wr_q;
    rd_ev = s.sy2.rd & ~s.rd_q;
    cs_wr = wr_ev & (s.sy2.sel == dfp_pkg::SEL_CS);
    db_wr = wr_ev & (s.sy2.sel == dfp_pkg::SEL_DB);
    n.med_go = 1'b0;
    // byte handshake pacing: request rises only after the shift delay
    if (!s.cs_tr && s.shift_cnt != 4'h0) begin
      n.shift_cnt = s.shift_cnt - 4'h1;
    end
    case (s.state)
      dfp_pkg::ST_IDLE: begin
        if (db_wr) begin
          n.db = s.sy2.wdata;
        end
        if (cs_wr && s.sy2.wdata[dfp_pkg::CS_GO] && s.cs_done) begin
          n.func = dfp_pkg::dfp_func_t'(s.sy2.wdata[dfp_pkg::CS_FUNC_LO +: 3]);
          n.fdens = s.sy2.wdata[dfp_pkg::CS_DENS];
          n.cs_done = 1'b0;
          n.cs_err = 1'b0;
          n.cs_tr = 1'b0;
          n.shift_cnt = dfp_pkg::SHIFT_CYC;
          n.count = 8'h00;
          case (dfp_pkg::dfp_func_t'(s.sy2.wdata[dfp_pkg::CS_FUNC_LO +: 3]))
            dfp_pkg::FN_FILL: begin
              n.crc_err = 1'b0;
              n.dens_err = 1'b0;
              n.deleted = 1'b0;
              n.init_done = 1'b0;
              n.state = dfp_pkg::ST_FILL;
            end
            dfp_pkg::FN_EMPTY: begin
              n.state = dfp_pkg::ST_EMPTY;
            end
            dfp_pkg::FN_WRITE, dfp_pkg::FN_WRDEL, dfp_pkg::FN_READ: begin
              n.unit = s.sy2.wdata[dfp_pkg::CS_UNIT];
              n.drv_dens = s.sy2.dbl[s.sy2.wdata[dfp_pkg::CS_UNIT]];
              if (s.sy2.wdata[dfp_pkg::CS_FUNC_LO]) begin
                n.crc_err = 1'b0;
                n.dens_err = 1'b0;
                n.deleted = 1'b0;
                n.init_done = 1'b0;
              end
              n.state = dfp_pkg::ST_GET_SEC;
            end
            dfp_pkg::FN_STATUS: begin
              n.unit = s.sy2.wdata[dfp_pkg::CS_UNIT];
              n.state = dfp_pkg::ST_STAT;
            end
            default: begin
              n.state = dfp_pkg::ST_FINISH;
            end
          endcase
        end
      end
      dfp_pkg::ST_FILL: begin
        if (!s.cs_tr && s.shift_cnt == 4'h0) begin
          n.cs_tr = 1'b1;
        end
        if (db_wr && s.cs_tr) begin
          buf_we = 1'b1;
          buf_wd = s.sy2.wdata[7:0];
          n.cs_tr = 1'b0;
          n.shift_cnt = dfp_pkg::SHIFT_CYC;
          n.count = s.count + 8'h01;
          if (s.count + 8'h01 == dfp_pkg::BUF_BYTES) begin
            n.state = dfp_pkg::ST_FINISH;
          end
        end
      end
      dfp_pkg::ST_EMPTY: begin
        if (!s.cs_tr && s.shift_cnt == 4'h0) begin
          n.db = {8'h00, buf_rd};
          n.cs_tr = 1'b1;
        end
        if (rd_ev && s.sy2.sel == dfp_pkg::SEL_DB && s.cs_tr) begin
          n.cs_tr = 1'b0;
          n.shift_cnt = dfp_pkg::SHIFT_CYC;
          n.count = s.count + 8'h01;
          if (s.count + 8'h01 == dfp_pkg::BUF_BYTES) begin
            n.state = dfp_pkg::ST_FINISH;
          end
        end
      end
      dfp_pkg::ST_GET_SEC, dfp_pkg::ST_GET_TRK: begin
        if (!s.cs_tr && s.shift_cnt == 4'h0) begin
          n.cs_tr = 1'b1;
        end
        if (db_wr && s.cs_tr) begin
          n.cs_tr = 1'b0;
          n.shift_cnt = dfp_pkg::SHIFT_CYC;
          if (s.state == dfp_pkg::ST_GET_SEC) begin
            n.sector = s.sy2.wdata[7:0];
            n.state = dfp_pkg::ST_GET_TRK;
          end else begin
            n.track = s.sy2.wdata[7:0];
            n.state = dfp_pkg::ST_CHECK;
          end
        end
      end
      dfp_pkg::ST_CHECK: begin
        if (s.drv_dens != s.fdens) begin
          n.dens_err = 1'b1;
          n.cs_err = 1'b1;
          n.state = dfp_pkg::ST_FINISH;
        end else if (s.track >= dfp_pkg::NUM_TRACKS) begin
          n.cs_err = 1'b1;
          n.state = dfp_pkg::ST_FINISH;
        end else if (s.sector == 8'h00 || s.sector > dfp_pkg::NUM_SECTORS) begin
          n.cs_err = 1'b1;
          n.state = dfp_pkg::ST_FINISH;
        end else begin
          n.med_go = 1'b1;
          n.state = dfp_pkg::ST_MEDIA;
        end
      end
      dfp_pkg::ST_MEDIA: begin
        // request stays low while the engine searches
        if (MED_TRK_ERR || MED_SEC_ERR) begin
          n.cs_err = 1'b1;
          n.state = dfp_pkg::ST_FINISH;
        end else if (MED_FOUND) begin
          n.count = 8'h00;
          n.crc = dfp_pkg::CRC_INIT;
          if (s.func == dfp_pkg::FN_READ) begin
            n.deleted = MED_DELETED;
            n.state = dfp_pkg::ST_RD_XFER;
          end else begin
            n.state = dfp_pkg::ST_WR_XFER;
          end
        end
      end
      dfp_pkg::ST_WR_XFER: begin
        // buffer is sent as is, valid or not, CRC always computed fresh
        if (!s.wr_valid || MED_WR_READY) begin
          n.count = s.count + 8'h01;
          n.wr_valid = 1'b1;
          if (s.count < dfp_pkg::BUF_BYTES) begin
            n.wr_data = buf_rd;
            n.crc = crc_step(s.crc, buf_rd);
          end else if (s.count == dfp_pkg::CRC_HI_IDX) begin
            n.wr_data = s.crc[15:8];
          end else if (s.count < dfp_pkg::REC_BYTES) begin
            n.wr_data = s.crc[7:0];
          end else begin
            n.wr_valid = 1'b0;
            n.count = s.count;
            n.state = dfp_pkg::ST_FINISH;
          end
        end
      end
      dfp_pkg::ST_RD_XFER: begin
        if (f_valid && f_ready) begin
          n.crc = crc_step(s.crc, f_data);
          n.count = s.count + 8'h01;
          if (s.count < dfp_pkg::BUF_BYTES) begin
            buf_we = 1'b1;
            buf_wd = f_data;
          end
        end
        if (s.count == dfp_pkg::REC_BYTES) begin
          if (s.crc != 16'h0000) begin
            n.crc_err = 1'b1;
            n.cs_err = 1'b1;
          end
          n.state = dfp_pkg::ST_FINISH;
        end
      end
      dfp_pkg::ST_STAT: begin
        n.drive_ready_flag = s.sy2.rdy[s.unit];
        n.drv_dens = s.sy2.dbl[s.unit];
        n.state = dfp_pkg::ST_FINISH;
      end
      dfp_pkg::ST_INIT: begin
        n.init_cnt = s.init_cnt + 16'h0001;
        if (s.init_cnt >= INIT_LAST) begin
          n.init_done = 1'b1;
          n.unit = 1'b0;
          n.drive_ready_flag = s.sy2.rdy[0];
          n.drv_dens = s.sy2.dbl[0];
          n.state = dfp_pkg::ST_FINISH;
        end
      end
      dfp_pkg::ST_PWRDN: begin
        if (s.sy2.pwr_ok) begin
          n.init_cnt = 16'h0000;
          n.state = dfp_pkg::ST_INIT;
        end
      end
      dfp_pkg::ST_FINISH: begin
        n.db = stat_word(s);
        n.cs_done = 1'b1;
        n.cs_tr = 1'b0;
        n.state = dfp_pkg::ST_IDLE;
      end
      default: begin
        n.state = dfp_pkg::ST_IDLE;
      end
    endcase
    if (cs_wr) begin
      n.cs_ie = s.sy2.wdata[dfp_pkg::CS_IE];
    end
    // power loss reruns the same initialize, so it clears errors and enable too
    if (!s.sy2.pwr_ok || s.sy2.bus_init || (cs_wr && s.sy2.wdata[dfp_pkg::CS_INIT])) begin
      n.state = s.sy2.pwr_ok ? dfp_pkg::ST_INIT : dfp_pkg::ST_PWRDN;
      n.init_cnt = 16'h0000;
      n.cs_done = 1'b0;
      n.cs_tr = 1'b0;
      n.cs_err = 1'b0;
      n.cs_ie = 1'b0;
      n.wr_valid = 1'b0;
      n.crc_err = 1'b0;
      n.dens_err = 1'b0;
      n.deleted = 1'b0;
      n.init_done = 1'b0;
      n.drive_ready_flag = 1'b0;
    end
    n.irq = n.cs_done & ~s.cs_done & n.cs_ie;
    n.rdata = (s.sy2.sel == dfp_pkg::SEL_DB) ? s.db : cs_word(s);
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      s <= '{state: dfp_pkg::ST_INIT, func: dfp_pkg::FN_FILL, default: '0};
    end else begin
      s <= n;
    end
  end

  // sector buffer has no reset; contents are undefined after power-up
  always_ff @(posedge CLOCK) begin
    if (buf_we) begin
      sbuf[s.count[6:0]] <= buf_wd;
    end
  end

  assign HOST_RDATA = s.rdata;
  assign HOST_IRQ = s.irq;
  assign MED_GO = s.med_go;
  assign MED_WRITE = ~s.func[0];
  assign MED_DELMARK = s.func[2];
  assign MED_UNIT = s.unit;
  assign MED_DOUBLE = s.fdens;
  assign MED_TRACK = s.track;
  assign MED_SECTOR = s.sector;
  assign MED_WR_DATA = s.wr_data;
  assign MED_WR_VALID = s.wr_valid;
endmodule // dfp_top

// ===== dv/dfp_top_asserts.sv
// Purpose: port checker for dfp_top
// Assumes: bench always sets interrupt enable
// Notes: bound at the foot of this file
`timescale 1ns/1ps
module dfp_top_asserts #(
  parameter logic [15:0] INIT_CYCLES = 16'h03e8,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic HOST_IRQ,
  input wire logic [1:0] DRV_DOUBLE,
  input wire logic MED_GO,
  input wire logic MED_WRITE,
  input wire logic MED_UNIT,
  input wire logic MED_DOUBLE,
  input wire logic [7:0] MED_TRACK,
  input wire logic [7:0] MED_SECTOR,
  input wire logic MED_TRK_ERR,
  input wire logic MED_SEC_ERR,
  input wire logic [7:0] MED_WR_DATA,
  input wire logic MED_WR_VALID,
  input wire logic MED_WR_READY
);
  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  a_irq_single: assert property (HOST_IRQ |=> !HOST_IRQ)
    else $error("irq longer than one cycle");
  a_go_single: assert property (MED_GO |=> !MED_GO [*4])
    else $error("seek start repeated");
  a_track_range: assert property (MED_GO |-> MED_TRACK < dfp_pkg::NUM_TRACKS)
    else $error("seek to bad track");
  a_sector_range: assert property (MED_GO |-> MED_SECTOR != 8'h00
    && MED_SECTOR <= dfp_pkg::NUM_SECTORS) else $error("seek to bad sector");
  a_go_density: assert property (MED_GO |-> MED_DOUBLE == DRV_DOUBLE[MED_UNIT])
    else $error("seek despite density mismatch");
  a_wr_hold: assert property (MED_WR_VALID && !MED_WR_READY |=>
    MED_WR_VALID && $stable(MED_WR_DATA)) else $error("write byte dropped");
  a_wr_only_write: assert property (MED_WR_VALID |-> MED_WRITE)
    else $error("write data on read");
  a_err_irq: assert property (MED_TRK_ERR || MED_SEC_ERR |-> ##[1:8] HOST_IRQ)
    else $error("no irq after abort");
endmodule // dfp_top_asserts

bind dfp_top dfp_top_asserts #(.INIT_CYCLES(INIT_CYCLES), .FIFO_DEPTH(FIFO_DEPTH))
  i_dfp_top_asserts (.CLOCK(CLOCK), .RSTN(RSTN), .HOST_IRQ(HOST_IRQ), .DRV_DOUBLE(DRV_DOUBLE),
  .MED_GO(MED_GO), .MED_WRITE(MED_WRITE), .MED_UNIT(MED_UNIT), .MED_DOUBLE(MED_DOUBLE),
  .MED_TRACK(MED_TRACK), .MED_SECTOR(MED_SECTOR), .MED_TRK_ERR(MED_TRK_ERR),
  .MED_SEC_ERR(MED_SEC_ERR), .MED_WR_DATA(MED_WR_DATA), .MED_WR_VALID(MED_WR_VALID),
  .MED_WR_READY(MED_WR_READY));

// ===== dv/dfp_media_model.sv
// Purpose: media engine model for the far side
// Assumes: one seek at a time
// Notes: random seek delay and stalls both ways
`timescale 1ns/1ps
module dfp_media_model (
  input wire logic clk,
  input wire logic [1:0] mode,
  input wire logic del,
  input wire logic go,
  input wire logic wr_op,
  input wire logic [7:0] wr_data,
  input wire logic wr_valid,
  input wire logic rd_ready,
  output logic found = 0,
  output logic trk_err = 0,
  output logic sec_err = 0,
  output logic deleted,
  output logic wr_ready = 0,
  output logic [7:0] rd_data = 8'h5a,
  output logic rd_valid = 0
);
  // ****************************************
  // engine
  // ****************************************
  logic [7:0] mem [130];
  logic [7:0] wbuf [130];
  int wn = 0;
  int i;
  assign deleted = del;
  always @(posedge clk) begin
    wr_ready <= 1'($urandom % 2);
    if (go) wn <= 0;
    else if (wr_valid && wr_ready && wn < 130) begin
      wbuf[wn] <= wr_data;
      wn <= wn + 1;
    end
  end
  always begin
    @(posedge clk);
    if (go) begin
      repeat (2 + $urandom % 30) @(posedge clk);
      found <= (mode == 2'h0);
      trk_err <= (mode == 2'h1);
      sec_err <= (mode == 2'h2);
      @(posedge clk);
      found <= 0;
      trk_err <= 0;
      sec_err <= 0;
      if (mode == 2'h0 && !wr_op) for (i = 0; i < 130; i++) begin
        rd_data <= mem[i];
        rd_valid <= 1;
        do @(posedge clk); while (!rd_ready);
        // released data shows the inverse so stale bytes never match
        if (i == 129 || $urandom % 3 == 0) begin
          rd_valid <= 0;
          rd_data <= ~mem[i];
          @(posedge clk);
        end
      end
    end
  end
endmodule // dfp_media_model

// ===== dv/dfp_top_test.sv
// Purpose: self-checking bench for dfp_top
// Assumes: media engine model on the far side
// Notes: short init count keeps the run brief
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((e) !== (g)) begin n_errors++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module dfp_top_test;
  // ****************************************
  // bench
  // ****************************************
  logic clock = 0, rstn = 0, host_sel = 0, host_wr = 0, host_rd = 0, del = 0;
  logic [15:0] host_wdata = 0, host_rdata, cs, st, v, crc;
  logic host_irq, pwr_ok = 1, bus_init = 0, compat = 1;
  logic [1:0] drv_ready = 2'b01, drv_double = 2'b10, mode = 0;
  logic go, wr_op, delmark, unit, dbl, found, trk_err, sec_err, deleted, wv, wrdy, rdv, rrdy;
  logic [7:0] trk, sec, track, sector, wd, rdd, fb [128];
  int n_errors = 0, check_count = 0, irq_n = 0, cyc = 0, i, f;
  always #2.5 clock = ~clock;
  dfp_top #(.INIT_CYCLES(16'h0004)) i_dfp_top (.CLOCK(clock), .RSTN(rstn), .HOST_SEL(host_sel),
    .HOST_WR(host_wr), .HOST_RD(host_rd), .HOST_WDATA(host_wdata), .HOST_RDATA(host_rdata),
    .HOST_IRQ(host_irq), .PWR_OK(pwr_ok), .BUS_INIT(bus_init), .COMPAT_MODE(compat),
    .DRV_READY(drv_ready), .DRV_DOUBLE(drv_double), .MED_GO(go), .MED_WRITE(wr_op),
    .MED_DELMARK(delmark), .MED_UNIT(unit), .MED_DOUBLE(dbl), .MED_TRACK(track),
    .MED_SECTOR(sector), .MED_FOUND(found), .MED_TRK_ERR(trk_err), .MED_SEC_ERR(sec_err),
    .MED_DELETED(deleted), .MED_WR_DATA(wd), .MED_WR_VALID(wv), .MED_WR_READY(wrdy),
    .MED_RD_DATA(rdd), .MED_RD_VALID(rdv), .MED_RD_READY(rrdy));
  dfp_media_model i_dfp_media_model (.clk(clock), .mode(mode), .del(del), .go(go),
    .wr_op(wr_op), .wr_data(wd), .wr_valid(wv), .rd_ready(rrdy), .found(found),
    .trk_err(trk_err), .sec_err(sec_err), .deleted(deleted), .wr_ready(wrdy),
    .rd_data(rdd), .rd_valid(rdv));
  task automatic summarize;
    if (n_errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (host_irq === 1'b1) irq_n++;
    if (cyc == 90000) begin
      n_errors++;
      summarize();
    end
  end
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    for (int k = 7; k >= 0; k--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[k]) ? dfp_pkg::CRC_POLY : 16'h0);
    return c;
  endfunction
  // strobes need three settled cycles each side
  task automatic wr(input logic s, input logic [15:0] d);
    @(negedge clock);
    host_sel = s;
    host_wdata = d;
    repeat (3) @(negedge clock);
    host_wr = 1;
    repeat (4) @(negedge clock);
    host_wr = 0;
    repeat (4) @(negedge clock);
  endtask
  task automatic rd(input logic s, output logic [15:0] d);
    @(negedge clock);
    host_sel = s;
    repeat (5) @(negedge clock);
    d = host_rdata;
  endtask
  task automatic rdb(output logic [15:0] d);
    rd(1, d);
    host_rd = 1;
    repeat (4) @(negedge clock);
    host_rd = 0;
    repeat (3) @(negedge clock);
  endtask
  task automatic wait_cs(input int b);
    cs = 0;
    for (int k = 0; k < 3000 && cs[b] !== 1'b1; k++) rd(0, cs);
    if (cs[b] !== 1'b1) begin
      n_errors++;
      summarize();
    end
  endtask
  task automatic cmd(input logic [2:0] fn, input logic u, input logic d);
    irq_n = 0;
    wr(0, {7'h00, d, 1'b0, 1'b1, 1'b0, u, fn, 1'b1});
  endtask
  task automatic addr;
    sec = 8'(1 + $urandom % 26);
    trk = 8'($urandom % 77);
    wait_cs(7);
    wr(1, {8'($urandom), sec});
    wait_cs(7);
    wr(1, {8'($urandom), trk});
  endtask
  task automatic fin;
    wait_cs(5);
    rd(1, st);
    `CHK("irq count", 1, irq_n)
  endtask
  initial begin
    void'($urandom(81));
    repeat (20) @(negedge clock);
    rstn = 1;
    wait_cs(5);
    rd(1, st);
    `CHK("init done", 1'b1, st[2])
    `CHK("ready", drv_ready[0], st[7])
    `CHK("density", 2'b00, st[5:4])
    cmd(dfp_pkg::FN_FILL, 1, 0);
    for (i = 0; i < 128; i++) begin
      fb[i] = 8'($urandom);
      wait_cs(7);
      `CHK("done in fill", 1'b0, cs[5])
      if (i == 64) rdb(v);
      wr(1, {8'($urandom), fb[i]});
    end
    fin();
    `CHK("fill status", 1'b0, st[2])
    for (f = 0; f < 2; f++) begin
      cmd(f ? dfp_pkg::FN_WRDEL : dfp_pkg::FN_WRITE, 0, 0);
      addr();
      fin();
      `CHK("track", trk, track)
      `CHK("sector", sec, sector)
      `CHK("mark", 1'(f), delmark)
      `CHK("bytes", 130, i_dfp_media_model.wn)
      crc = dfp_pkg::CRC_INIT;
      for (i = 0; i < 128; i++) begin
        `CHK("written", fb[i], i_dfp_media_model.wbuf[i])
        crc = crc_step(crc, fb[i]);
      end
      `CHK("crc", crc, {i_dfp_media_model.wbuf[128], i_dfp_media_model.wbuf[129]})
    end
    crc = dfp_pkg::CRC_INIT;
    for (i = 0; i < 128; i++) begin
      i_dfp_media_model.mem[i] = 8'($urandom);
      crc = crc_step(crc, i_dfp_media_model.mem[i]);
    end
    i_dfp_media_model.mem[128] = crc[15:8];
    i_dfp_media_model.mem[129] = crc[7:0];
    del = 1;
    for (f = 0; f < 2; f++) begin
      cmd(dfp_pkg::FN_READ, 0, 0);
      addr();
      fin();
      `CHK("crc error", 1'(f), st[0])
      `CHK("error flag", 1'(f), cs[15])
      `CHK("deleted", 1'(1 - f), st[6])
      if (f == 0) begin
        cmd(dfp_pkg::FN_EMPTY, 1, 0);
        for (i = 0; i < 128; i++) begin
          wait_cs(7);
          rdb(v);
          `CHK("empty byte", {8'h00, i_dfp_media_model.mem[i]}, v)
        end
        fin();
        i_dfp_media_model.mem[129] ^= 8'h01;
        del = 0;
      end
    end
    for (f = 1; f < 4; f++) begin
      mode = 2'(f % 3);
      cmd(dfp_pkg::FN_WRITE, 0, f == 3);
      addr();
      fin();
      `CHK("abort error", 1'b1, cs[15])
    end
    `CHK("dens error", 1'b1, st[3])
    mode = 0;
    cmd(dfp_pkg::FN_STATUS, 1, 0);
    fin();
    `CHK("error cleared", 1'b0, cs[15])
    `CHK("unit", 1'b1, st[8])
    `CHK("ready 1", drv_ready[1], st[7])
    `CHK("double", 2'b11, st[5:4])
    for (f = 4; f < 8; f += 3) begin
      compat = (f == 4);
      cmd(3'(f), 0, 0);
      fin();
      `CHK("compat", {1'b1, compat}, st[5:4])
    end
    for (f = 0; f < 3; f++) begin
      wr(0, 16'h0040);
      if (f == 0) wr(0, 16'h4040);
      else begin
        {pwr_ok, bus_init} = (f == 1) ? 2'b11 : 2'b00;
        repeat (6) @(negedge clock);
        {pwr_ok, bus_init} = 2'b10;
      end
      repeat (8) @(negedge clock);
      wait_cs(5);
      rd(1, st);
      `CHK("reinit", 1'b1, st[2])
      `CHK("ie cleared", 1'b0, cs[6])
    end
    summarize();
  end
endmodule // dfp_top_test
